/* File: inc/nfc_tx_regs.vh */
// Purpose: Register map and timing constants of the NFC transmitter control
// Assumes: APB data 32 bits, core_clk period 8 ns
// Notes:   Shared by the top level and the ramp controller
`ifndef NFC_TX_REGS_VH
`define NFC_TX_REGS_VH
`define TXC_CTRL_OFS      12'h000
`define TXC_DRIVE_OFS     12'h004
`define TXC_STATUS_OFS    12'h008
`define TXC_CTRL_W        10
`define TXC_CTRL_RST      10'h000
`define TXC_DRIVE_W       16
`define TXC_DRIVE_RST     16'h0000
`define TXC_TX_EN_BIT     0
`define TXC_RX_EN_BIT     1
`define TXC_SINGLE_BIT    2
`define TXC_SEL_B_BIT     3
`define TXC_AM_BIT        4
`define TXC_LM_INT_BIT    5
`define TXC_LM_EXT_BIT    6
`define TXC_LM_INV_BIT    7
`define TXC_SLOW_BIT      8
`define TXC_PT_BIT        9
`define TXC_RES_LSB       0
`define TXC_DEPTH_LSB     4
`define TXC_IDLE_LSB      8
`define TXC_MODZ_LSB      12
`define TXC_CLK_PERIOD_NS 8
`define TXC_RAMP_TIME_NS  15000
`define TXC_RAMP_CYCLES   ((`TXC_RAMP_TIME_NS + `TXC_CLK_PERIOD_NS - 1) / `TXC_CLK_PERIOD_NS)
`define TXC_RAMP_STEPS    255
`define TXC_STEP_CYCLES   ((`TXC_RAMP_CYCLES + `TXC_RAMP_STEPS - 1) / `TXC_RAMP_STEPS)
`define TXC_DISCHARGE_MS  2
`define TXC_DISCHARGE_CYCLES ((`TXC_DISCHARGE_MS * 1000000) / `TXC_CLK_PERIOD_NS)
`endif

/* File: core/tx_segment_select.v */
// Purpose: Turn a 4-bit resistance code into eight segment enables
// Assumes: Code is steady for one cycle when load is high
// Notes:   Output holds while load is low
`timescale 1ns/1ps
`default_nettype none
module tx_segment_select #(
	parameter SEGS = 8
) (
	input  wire            core_clk,
	input  wire            rst,
	input  wire            load,
	input  wire            active,
	input  wire [3:0]      code,
	output reg  [SEGS-1:0] seg_en_q
);
	// Each code step up to 7 drops one more top segment; one always stays on
	function [SEGS-1:0] thermo;
		input [3:0] c;
		integer k;
		begin
			thermo = {SEGS{1'b1}};
			for (k = 0; k < SEGS - 1; k = k + 1)
				if (c > k)
					thermo[SEGS-1-k] = 1'b0;
		end
	endfunction

	// Segments switched individually; all on in reset, idle driver fully off on load
	always @(posedge core_clk)
	begin
		if (rst)
			seg_en_q <= {SEGS{1'b1}};
		else if (load)
			seg_en_q <= active ? thermo(code) : {SEGS{1'b0}};
	end
endmodule // tx_segment_select
`default_nettype wire

/* File: core/tx_ramp_ctrl.v */
// Purpose: Slow field ramp of the driver regulator
// Assumes: slow_ramp and tx_enable are register bits
// Notes:   Level 0 is a collapsed regulator, all ones is full supply
`timescale 1ns/1ps
`default_nettype none
`include "nfc_tx_regs.vh"
module tx_ramp_ctrl #(
	parameter DISCHARGE_CYCLES = `TXC_DISCHARGE_CYCLES
) (
	input  wire       core_clk,
	input  wire       rst,
	input  wire       slow_ramp,
	input  wire       tx_enable,
	output reg  [7:0] level_q,
	output reg        collapse_q,
	output reg        discharged_q
);
	localparam [15:0] STEP = `TXC_STEP_CYCLES;
	reg [15:0] step_cnt_q;
	reg [31:0] dis_cnt_q;

	// With slow_ramp set, collapse while off and climb one step per STEP cycles once enabled
	always @(posedge core_clk)
	begin
		if (rst)
		begin
			level_q    <= 8'hFF;
			step_cnt_q <= 16'h0000;
			collapse_q <= 1'b0;
		end
		else
		begin
			collapse_q <= slow_ramp & ~tx_enable;
			if (!tx_enable)
			begin
				level_q    <= slow_ramp ? 8'h00 : 8'hFF;
				step_cnt_q <= 16'h0000;
			end
			else if (!slow_ramp)
				level_q <= 8'hFF;
			else if (level_q != 8'hFF)
			begin
				// Spreads the climb over the whole transition time
				if (step_cnt_q >= STEP - 16'h0001)
				begin
					step_cnt_q <= 16'h0000;
					level_q    <= level_q + 8'h01;
				end
				else
					step_cnt_q <= step_cnt_q + 16'h0001;
			end
		end
	end

	// Tells software when the collapsed supply has had time to discharge
	always @(posedge core_clk)
	begin
		if (rst || !(slow_ramp && !tx_enable))
		begin
			dis_cnt_q    <= 32'h0000_0000;
			discharged_q <= 1'b0;
		end
		else if (dis_cnt_q >= DISCHARGE_CYCLES - 1)
			discharged_q <= 1'b1;
		else
			dis_cnt_q <= dis_cnt_q + 32'h0000_0001;
	end
endmodule // tx_ramp_ctrl
`default_nettype wire

/* File: core/nfc_tx_driver_control.v */
// Purpose: Transmitter driver control of an NFC front end, APB slave
// Assumes: All inputs synchronous to core_clk; zero-wait APB
// Notes:   Carrier, segments and gate outputs are registered
`timescale 1ns/1ps
`default_nettype none
`include "nfc_tx_regs.vh"
module nfc_tx_driver_control #(
	parameter DISCHARGE_CYCLES = `TXC_DISCHARGE_CYCLES,
	parameter SEGS             = 8
) (
	input  wire            core_clk,
	input  wire            rst,
	input  wire [11:0]     paddr,
	input  wire            psel,
	input  wire            penable,
	input  wire            pwrite,
	input  wire [31:0]     pwdata,
	input  wire [3:0]      pstrb,
	output reg  [31:0]     prdata,
	output wire            pready,
	output wire            pslverr,
	input  wire            tx_modulate,
	input  wire            load_mod_signal,
	input  wire            field_clk_present,
	output reg             antenna_drive_out_a,
	output reg             antenna_drive_out_b,
	output wire [SEGS-1:0] seg_en_a,
	output wire [SEGS-1:0] seg_en_b,
	output reg             modulation_regulator_supply,
	output reg  [3:0]      amplitude_depth_level,
	output reg             load_mod_gate_out,
	output wire            regulator_collapse,
	output wire [7:0]      driver_regulator_supply,
	output reg             rx_enable,
	output reg             rx_input_b_select
);
	reg  [`TXC_CTRL_W-1:0]  ctrl_q;
	reg  [`TXC_DRIVE_W-1:0] drive_q;
	wire                    ramp_discharged;
	wire                    setup_ph;
	wire                    access_ph;
	wire                    mapped;
	wire [31:0]             status_word;

	// Control bits
	wire tx_en        = ctrl_q[`TXC_TX_EN_BIT];
	wire rx_en        = ctrl_q[`TXC_RX_EN_BIT];
	wire single_drv   = ctrl_q[`TXC_SINGLE_BIT];
	wire second_output_select = ctrl_q[`TXC_SEL_B_BIT];
	wire modulation_type_select = ctrl_q[`TXC_AM_BIT];
	wire internal_load_mod_enable = ctrl_q[`TXC_LM_INT_BIT];
	wire external_load_mod_enable = ctrl_q[`TXC_LM_EXT_BIT];
	wire external_load_mod_invert = ctrl_q[`TXC_LM_INV_BIT];
	wire slow_ramp    = ctrl_q[`TXC_SLOW_BIT];
	wire pt_mode      = ctrl_q[`TXC_PT_BIT];

	// Drive fields
	wire [3:0] drive_res = drive_q[`TXC_RES_LSB +: 4];
	wire [3:0] depth     = drive_q[`TXC_DEPTH_LSB +: 4];
	wire [3:0] target_idle_impedance = drive_q[`TXC_IDLE_LSB +: 4];
	wire [3:0] target_modulated_impedance = drive_q[`TXC_MODZ_LSB +: 4];

	// Register index decode, shared by read and write paths
	function [1:0] reg_sel;
		input [11:0] a;
		begin
			case (a)
				`TXC_CTRL_OFS:   reg_sel = 2'h1;
				`TXC_DRIVE_OFS:  reg_sel = 2'h2;
				`TXC_STATUS_OFS: reg_sel = 2'h3;
				default:         reg_sel = 2'h0;
			endcase
		end
	endfunction

	// Byte lane merge for partial writes
	function [31:0] lane_merge;
		input [31:0] old;
		input [31:0] wd;
		input [3:0]  st;
		integer b;
		begin
			lane_merge = old;
			for (b = 0; b < 4; b = b + 1)
				if (st[b])
					lane_merge[8*b +: 8] = wd[8*b +: 8];
		end
	endfunction

	// Bus phases; answers come in the first access cycle
	assign setup_ph  = psel & ~penable;
	assign access_ph = psel & penable;
	assign mapped    = reg_sel(paddr) != 2'h0;
	assign pready    = 1'b1;
	// Unmapped offsets and writes to the status word are errors
	assign pslverr   = access_ph &
		(~mapped | (pwrite & (reg_sel(paddr) == 2'h3)));

	// Merged write words; unimplemented upper bits are dropped on purpose
	wire [31:0] ctrl_wr  = lane_merge({22'h000000, ctrl_q}, pwdata,
		pstrb);
	wire [31:0] drive_wr = lane_merge({16'h0000, drive_q}, pwdata,
		pstrb);

	// Control register; transmitter and receiver enables kept apart
	always @(posedge core_clk)
	begin
		if (rst)
			ctrl_q <= `TXC_CTRL_RST;
		else if (access_ph && pwrite && reg_sel(paddr) == 2'h1)
			ctrl_q <= ctrl_wr[`TXC_CTRL_W-1:0];
	end

	// Drive register; resistance resets to all segments on
	always @(posedge core_clk)
	begin
		if (rst)
			drive_q <= `TXC_DRIVE_RST;
		else if (access_ph && pwrite && reg_sel(paddr) == 2'h2)
			drive_q <= drive_wr[`TXC_DRIVE_W-1:0];
	end

	// Live status seen by software
	assign status_word = {
		8'h00,
		ramp_discharged,
		regulator_collapse,
		field_clk_present,
		load_mod_gate_out,
		modulation_regulator_supply,
		antenna_drive_out_b,
		antenna_drive_out_a,
		driver_regulator_supply == 8'hFF,
		seg_en_b,
		seg_en_a
	};

	// Read data is captured in setup so it comes from a flop in access
	always @(posedge core_clk)
	begin
		if (rst)
			prdata <= 32'h0000_0000;
		else if (setup_ph && !pwrite)
		begin
			case (reg_sel(paddr))
				2'h1:    prdata <= {22'h000000, ctrl_q};
				2'h2:    prdata <= {16'h0000, drive_q};
				2'h3:    prdata <= status_word;
				default: prdata <= 32'h0000_0000;
			endcase
		end
	end

	// Which output pair a single driver uses
	wire use_a = ~single_drv | ~second_output_select;
	wire use_b = ~single_drv | second_output_select;

	// Resistance code in use: target mode swaps between two impedances
	reg [3:0] code_d;
	always @*
	begin
		code_d = drive_res;
		if (pt_mode && internal_load_mod_enable)
			code_d = load_mod_signal ?
				target_modulated_impedance :
				target_idle_impedance;
	end

	// In target mode codes propagate only with a field clock
	wire seg_load = ~pt_mode | field_clk_present;
	wire seg_live = tx_en | pt_mode;

	tx_segment_select #(
		.SEGS (SEGS)
	) u_seg_a (
		.core_clk (core_clk),
		.rst      (rst),
		.load     (seg_load),
		.active   (seg_live & use_a),
		.code     (code_d),
		.seg_en_q (seg_en_a)
	);

	tx_segment_select #(
		.SEGS (SEGS)
	) u_seg_b (
		.core_clk (core_clk),
		.rst      (rst),
		.load     (seg_load),
		.active   (seg_live & use_b),
		.code     (code_d),
		.seg_en_q (seg_en_b)
	);

	tx_ramp_ctrl #(
		.DISCHARGE_CYCLES (DISCHARGE_CYCLES)
	) u_ramp (
		.core_clk     (core_clk),
		.rst          (rst),
		.slow_ramp    (slow_ramp),
		.tx_enable    (tx_en),
		.level_q      (driver_regulator_supply),
		.collapse_q   (regulator_collapse),
		.discharged_q (ramp_discharged)
	);

	// Carrier keying; keying gaps stop the carrier, AM swaps supply
	wire carrier = tx_en & ~pt_mode;
	wire ook_gap = ~modulation_type_select & tx_modulate;
	always @(posedge core_clk)
	begin
		if (rst)
		begin
			antenna_drive_out_a         <= 1'b0;
			antenna_drive_out_b         <= 1'b0;
			modulation_regulator_supply <= 1'b0;
		end
		else
		begin
			antenna_drive_out_a <= carrier & use_a & ~ook_gap;
			antenna_drive_out_b <= carrier & use_b & ~ook_gap;
			modulation_regulator_supply <= carrier &
				modulation_type_select & tx_modulate;
		end
	end

	// Depth code 0 is 5 percent, 15 is 30 percent
	always @(posedge core_clk)
	begin
		if (rst)
			amplitude_depth_level <= 4'h0;
		else
			amplitude_depth_level <= depth;
	end

	// External gate runs independently of driver load modulation
	always @(posedge core_clk)
	begin
		if (rst)
			load_mod_gate_out <= 1'b0;
		else
			load_mod_gate_out <= external_load_mod_enable &
				(load_mod_signal ^ external_load_mod_invert);
	end

	// Receiver enable follows its own bit; input pair follows the driver choice
	always @(posedge core_clk)
	begin
		if (rst)
		begin
			rx_enable         <= 1'b0;
			rx_input_b_select <= 1'b0;
		end
		else
		begin
			rx_enable         <= rx_en;
			rx_input_b_select <= single_drv & second_output_select;
		end
	end
endmodule // nfc_tx_driver_control
`default_nettype wire

/* File: dv/antenna_tank_model.sv */
// Purpose: Outside field as seen across the antenna tank
// Assumes: Bench switches the outside field on and off
// Notes:   Recovered clock flag lags the field by one cycle
`timescale 1ns/1ps
`default_nettype none
module antenna_tank_model (
	input  wire logic core_clk,
	input  wire logic ext_field,
	output logic      field_clk_present
);
	// No outside field means no recovered clock at all
	always_ff @(posedge core_clk)
		field_clk_present <= ext_field;
endmodule // antenna_tank_model
`default_nettype wire

/* File: dv/tx_ctrl_sva.sv */
// Purpose: Port assertions for the transmitter driver control
// Assumes: Whole-word register writes
// Notes:   Shadows CTRL and DRIVE from the APB writes
`timescale 1ns/1ps
`default_nettype none
`include "nfc_tx_regs.vh"
module tx_ctrl_sva #(
	parameter SEGS = 8
) (
	input wire logic            core_clk,
	input wire logic            rst,
	input wire logic [11:0]     paddr,
	input wire logic            psel,
	input wire logic            penable,
	input wire logic            pwrite,
	input wire logic [31:0]     pwdata,
	input wire logic            tx_modulate,
	input wire logic            load_mod_signal,
	input wire logic            field_clk_present,
	input wire logic            antenna_drive_out_a,
	input wire logic            antenna_drive_out_b,
	input wire logic [SEGS-1:0] seg_en_a,
	input wire logic            modulation_regulator_supply,
	input wire logic [3:0]      amplitude_depth_level,
	input wire logic            load_mod_gate_out,
	input wire logic            regulator_collapse,
	input wire logic [7:0]      driver_regulator_supply
);
	logic [9:0]  c_q;
	logic [15:0] d_q;
	// Decoded control terms
	wire       wr  = psel && penable && pwrite;
	wire       on  = c_q[0] && !c_q[9];
	wire       ook = !c_q[4] && tx_modulate;
	wire       ua  = !c_q[2] || !c_q[3];
	wire       ub  = !c_q[2] || c_q[3];
	wire [3:0] k   = load_mod_signal ? d_q[15:12] : d_q[11:8];
	function automatic logic [7:0] seg(input logic [3:0] x);
		return (x >= 4'h7) ? 8'h01 : 8'hFF >> x;
	endfunction
	// Shadows load on the same edge as the design
	always_ff @(posedge core_clk)
		if (rst)
			{c_q, d_q} <= 26'h0;
		else if (wr && paddr == `TXC_CTRL_OFS)
			c_q <= pwdata[9:0];
		else if (wr && paddr == `TXC_DRIVE_OFS)
			d_q <= pwdata[15:0];
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	sequence s_hold;
		$stable(driver_regulator_supply) [*7];
	endsequence
	property p_drive;
		1 |=> antenna_drive_out_a == $past(on && ua && !ook)
			&& antenna_drive_out_b == $past(on && ub && !ook);
	endproperty
	a_drive: assert property (p_drive) else $error("drive");
	property p_am;
		c_q[4] && on |=> modulation_regulator_supply == $past(tx_modulate);
	endproperty
	a_am: assert property (p_am) else $error("am supply");
	property p_depth;
		1 |=> amplitude_depth_level == $past(d_q[7:4]);
	endproperty
	a_depth: assert property (p_depth) else $error("depth");
	property p_gate;
		1 |=> load_mod_gate_out == $past(c_q[6] && (load_mod_signal ^ c_q[7]));
	endproperty
	a_gate: assert property (p_gate) else $error("gate");
	property p_seg;
		on && ua |=> seg_en_a == $past(seg(d_q[3:0]));
	endproperty
	a_seg: assert property (p_seg) else $error("segments");
	property p_seg_pt;
		c_q[9] && c_q[5] && !c_q[2] && field_clk_present
			|=> seg_en_a == $past(seg(k));
	endproperty
	a_seg_pt: assert property (p_seg_pt) else $error("target");
	property p_collapse;
		c_q[8] && !c_q[0] |=> regulator_collapse
			&& driver_regulator_supply == 8'h00;
	endproperty
	a_collapse: assert property (p_collapse) else $error("collapse");
	// Each ramp step lasts eight cycles
	property p_ramp;
		c_q[8] && c_q[0] && driver_regulator_supply != 8'hFF
			&& $changed(driver_regulator_supply) |=> s_hold ##1
			driver_regulator_supply == $past(driver_regulator_supply) + 8'h01;
	endproperty
	a_ramp: assert property (p_ramp) else $error("ramp");
endmodule // tx_ctrl_sva
bind nfc_tx_driver_control tx_ctrl_sva #(.SEGS(SEGS)) i_tx_ctrl_sva (
	.core_clk, .rst, .paddr, .psel, .penable, .pwrite, .pwdata,
	.tx_modulate, .load_mod_signal, .field_clk_present,
	.antenna_drive_out_a, .antenna_drive_out_b, .seg_en_a,
	.modulation_regulator_supply, .amplitude_depth_level,
	.load_mod_gate_out, .regulator_collapse, .driver_regulator_supply);
`default_nettype wire

/* File: dv/tb.sv */
// Purpose: Self-checking bench for the transmitter driver control
// Assumes: Discharge count shortened to 20 cycles
// Notes:   Model keeps its own copies of CTRL and DRIVE
`timescale 1ns/1ps
`default_nettype none
`include "nfc_tx_regs.vh"
module tb;
	logic        core_clk = 1'b0;
	logic        rst = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic        tx_modulate = 1'b0;
	logic        load_mod_signal = 1'b0;
	logic        ext_field = 1'b1;
	logic        err;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] rd;
	wire  [31:0] prdata;
	wire  [7:0]  seg_en_a, seg_en_b, driver_regulator_supply;
	wire  [3:0]  amplitude_depth_level;
	wire         pready, pslverr, field_clk_present, antenna_drive_out_a;
	wire         antenna_drive_out_b, modulation_regulator_supply;
	wire         load_mod_gate_out, regulator_collapse, rx_enable;
	wire         rx_input_b_select;
	int          failures = 0, checks = 0, seed = 66, i, n, c, d, sa, sb;
	nfc_tx_driver_control #(.DISCHARGE_CYCLES(20)) i_nfc_tx_driver_control (
		.core_clk, .rst, .paddr, .psel, .penable, .pwrite, .pwdata,
		.pstrb(4'hF), .prdata, .pready, .pslverr, .tx_modulate,
		.load_mod_signal, .field_clk_present, .antenna_drive_out_a,
		.antenna_drive_out_b, .seg_en_a, .seg_en_b,
		.modulation_regulator_supply, .amplitude_depth_level,
		.load_mod_gate_out, .regulator_collapse, .driver_regulator_supply,
		.rx_enable, .rx_input_b_select);
	antenna_tank_model i_antenna_tank_model (.core_clk, .ext_field,
		.field_clk_present);
	// 125 MHz clock
	always #4 core_clk = ~core_clk;
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("unexpected at %0t: %h vs %h", $time, seen, exp);
		end
	endtask
	task results;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task stall;
		failures++;
		results;
	endtask
	// One APB transfer; an idle edge first keeps drivers race free
	task apb(input bit w, input logic [11:0] a, input logic [31:0] wd);
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge core_clk);
		penable <= 1'b1;
		n = 0;
		do @(posedge core_clk) n++;
		while (pready !== 1'b1 && n < 50);
		if (n >= 50)
			stall;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	function automatic int segc(input int x);
		return x >= 7 ? 8'h01 : 8'hFF >> x;
	endfunction
	// Expected outputs; segments keep old value when asked to hold
	task check_all(input bit upd);
		int on, ua, ub, m, k;
		on = c[0] && !c[9];
		ua = !c[2] || !c[3];
		ub = !c[2] || c[3];
		m = !c[4] && tx_modulate;
		k = c[9] && c[5] ? (load_mod_signal ? d[15:12] : d[11:8]) : d[3:0];
		if (upd || !c[9] || field_clk_present)
		begin
			sa = ua && (c[0] || c[9]) ? segc(k) : 0;
			sb = ub && (c[0] || c[9]) ? segc(k) : 0;
		end
		chk(antenna_drive_out_a, on && ua && !m);
		chk(antenna_drive_out_b, on && ub && !m);
		chk(modulation_regulator_supply, on && c[4] && tx_modulate);
		chk(seg_en_a, sa);
		chk(seg_en_b, sb);
		chk(amplitude_depth_level, d[7:4]);
		chk(load_mod_gate_out, c[6] && (load_mod_signal ^ c[7]));
		chk({rx_enable, rx_input_b_select}, {c[1], c[2] && c[3]});
		chk(driver_regulator_supply, 8'hFF);
	endtask
	// Reset, random configurations, slow ramp, then refusals
	initial
	begin
		repeat (16) @(posedge core_clk);
		chk(seg_en_a, 8'hFF);
		chk(prdata, 0);
		rst <= 1'b0;
		apb(0, `TXC_DRIVE_OFS, 0);
		chk(rd, 0);
		for (i = 0; i < 60; i++)
		begin
			c = i ? $random(seed) & 32'h2FF : 1;
			d = i ? $random(seed) & 32'hFFFF : 0;
			ext_field <= 1'b1;
			apb(1, `TXC_DRIVE_OFS, d);
			apb(1, `TXC_CTRL_OFS, c);
			apb(0, `TXC_CTRL_OFS, 0);
			chk(rd, c);
			apb(0, `TXC_DRIVE_OFS, 0);
			chk(rd, d);
			tx_modulate <= $random(seed);
			ext_field <= $random(seed);
			repeat (4) @(posedge core_clk);
			check_all(1);
			load_mod_signal <= ~load_mod_signal;
			repeat (4) @(posedge core_clk);
			check_all(0);
		end
		apb(1, `TXC_CTRL_OFS, 32'h100);
		repeat (30) @(posedge core_clk);
		chk({regulator_collapse, driver_regulator_supply}, 9'h100);
		apb(0, `TXC_STATUS_OFS, 0);
		chk(rd[23:22], 2'h3);
		apb(1, `TXC_CTRL_OFS, 32'h101);
		n = 0;
		do @(posedge core_clk) n++;
		while (driver_regulator_supply !== 8'hFF && n < 3000);
		if (n >= 3000)
			stall;
		chk(n > 2024 && n < 2056, 1);
		apb(1, `TXC_CTRL_OFS, 32'h001);
		apb(1, `TXC_STATUS_OFS, 32'hFFFFFFFF);
		chk(err, 1);
		apb(0, 12'h00C, 0);
		chk(err, 1);
		chk(rd, 0);
		results;
	end
endmodule // tb
`default_nettype wire
